// ==== hdl/cfg_regs_pkg.sv ====
/*
 * Constants for the switching/modulator and serial audio port configuration registers.
 * Assumes an 8-bit register access port with byte addresses, one clock domain.
 */
package cfg_regs_pkg;
    localparam logic [7:0] SWMOD_OFFSET = 8'h02;
    localparam logic [7:0] PORT_OFFSET = 8'h03;
    localparam logic [7:0] SWMOD_RESET = 8'h62;
    localparam logic [7:0] PORT_RESET = 8'h04;
    localparam logic [7:0] SWMOD_WMASK = 8'h77;
    // Field positions
    localparam int SWRATE_LSB = 4;
    localparam int OSR_BIT = 2;
    localparam int PHASE_LSB = 0;
    localparam int RATE_LSB = 6;
    localparam int HALF_BIT = 5;
    localparam int SLOT16_BIT = 4;
    localparam int SWAP_BIT = 3;
    localparam int FMT_LSB = 0;
    // Switching rate multiples of fs
    localparam logic [7:0] MULT_8 = 8'h08;
    localparam logic [7:0] MULT_10 = 8'h0A;
    localparam logic [7:0] MULT_38 = 8'h26;
    localparam logic [7:0] MULT_44 = 8'h2C;
    localparam logic [7:0] MULT_48 = 8'h30;
    typedef enum logic [1:0] {RATE_44K1, RATE_48K, RATE_96K, RATE_RSVD} input_rate_t;
    typedef enum logic [2:0] {FMT_RJ24, FMT_RJ20, FMT_RJ18, FMT_RJ16, FMT_I2S, FMT_LJ, FMT_DSP,
        FMT_RSVD} input_format_t;
endpackage : cfg_regs_pkg

// ==== hdl/switch_decode.sv ====
/*
 * Decodes the switching/modulator register into multiplier, OSR and phase.
 * Assumes the register value comes from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module switch_decode (
    input wire logic clk, // System clock
    input wire logic rst_n, // Sync reset, active low
    input wire logic [7:0] reg_value, // Stored register
    output logic [7:0] switch_mult, // Switching rate / fs, 0 = reserved
    output logic osr_128, // High for 128x oversampling
    output logic [6:0] phase_deg // Channel phase offset in degrees
);
    logic [2:0] code;
    assign code = reg_value[cfg_regs_pkg::SWRATE_LSB +: 3];

    // Registered decode; reserved codes give zero so the modulator holds
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            switch_mult <= cfg_regs_pkg::MULT_44;
            osr_128 <= 1'b0;
            phase_deg <= 7'd45;
        end
        else
        begin
            unique case (code)
                3'h0: switch_mult <= cfg_regs_pkg::MULT_8; // [RQ2]
                3'h1: switch_mult <= cfg_regs_pkg::MULT_10; // [RQ2]
                3'h5: switch_mult <= cfg_regs_pkg::MULT_38; // [RQ2]
                3'h6: switch_mult <= cfg_regs_pkg::MULT_44; // [RQ2]
                3'h7: switch_mult <= cfg_regs_pkg::MULT_48; // [RQ2]
                default: switch_mult <= 8'h00; // [RQ13]
            endcase
            osr_128 <= reg_value[cfg_regs_pkg::OSR_BIT]; // [RQ4]
            unique case (reg_value[cfg_regs_pkg::PHASE_LSB +: 2])
                2'h0: phase_deg <= 7'd0; // [RQ5]
                2'h1: phase_deg <= 7'd30; // [RQ5]
                2'h2: phase_deg <= 7'd45; // [RQ5]
                2'h3: phase_deg <= 7'd60; // [RQ5]
            endcase
        end
    end
endmodule : switch_decode
`default_nettype wire

// ==== hdl/sap_decode.sv ====
/*
 * Decodes the serial audio port register into receiver controls.
 * Assumes the register value comes from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module port_decode (
    input wire logic clk, // System clock
    input wire logic rst_n, // Sync reset, active low
    input wire logic [7:0] reg_value, // Stored register
    output logic [1:0] input_rate_select, // Sample rate code
    output logic eight_slot_half_select, // Use last four TDM slots
    output logic slot_16bit, // TDM slot width 16
    output logic pair_swap, // Swap ch1/2 with ch3/4
    output logic [2:0] input_format, // Format code
    output logic [5:0] word_bits, // Right-justified word width, 0 = 16 or 24
    output logic format_valid // Format code not reserved
);
    cfg_regs_pkg::input_format_t fmt;
    assign fmt = cfg_regs_pkg::input_format_t'(reg_value[cfg_regs_pkg::FMT_LSB +: 3]);

    // Registered copies of the fields plus word width decode
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            input_rate_select <= 2'h0;
            eight_slot_half_select <= 1'b0;
            slot_16bit <= 1'b0;
            pair_swap <= 1'b0;
            input_format <= 3'h4;
            word_bits <= 6'd0;
            format_valid <= 1'b1;
        end
        else
        begin
            input_rate_select <= reg_value[cfg_regs_pkg::RATE_LSB +: 2]; // [RQ7]
            eight_slot_half_select <= reg_value[cfg_regs_pkg::HALF_BIT]; // [RQ8]
            slot_16bit <= reg_value[cfg_regs_pkg::SLOT16_BIT]; // [RQ9]
            pair_swap <= reg_value[cfg_regs_pkg::SWAP_BIT]; // [RQ10]
            input_format <= reg_value[cfg_regs_pkg::FMT_LSB +: 3]; // [RQ11]
            format_valid <= (fmt != cfg_regs_pkg::FMT_RSVD); // [RQ13]
            unique case (fmt)
                cfg_regs_pkg::FMT_RJ24: word_bits <= 6'd24; // [RQ11]
                cfg_regs_pkg::FMT_RJ20: word_bits <= 6'd20; // [RQ11]
                cfg_regs_pkg::FMT_RJ18: word_bits <= 6'd18; // [RQ11]
                cfg_regs_pkg::FMT_RJ16: word_bits <= 6'd16; // [RQ11]
                // Framed modes take 16- or 24-bit words, width auto-detected downstream
                default: word_bits <= 6'd0; // [RQ12]
            endcase
        end
    end
endmodule : port_decode
`default_nettype wire

// ==== hdl/pwm_and_serial_port_config_regs.sv ====
/*
 * Switching/modulator control and serial audio port control registers,
 * with decoded outputs for the modulator and the serial receiver.
 * Assumes a simple synchronous 8-bit register port from the host controller
 * logic on the same clock: one-cycle write strobe, read data one cycle later.
 */
// Behaviour
// RQ1 - 8-bit register at 0x02, reset 0x62, bits 7 and 3 read zero.
// RQ2 - Bits 6:4 pick switching 8,10,38,44,48 times fs; others reserved.
// RQ3 - Host must not pick 48 times fs at 48 kHz input rate.
// RQ4 - Bit 2 selects 64x oversampling when clear, 128x when set.
// RQ5 - Bits 1:0 set channel phase offset 0, 30, 45 or 60 degrees.
// RQ6 - 8-bit serial port register at 0x03, reset 0x04, fully read/write.
// RQ7 - Bits 7:6 select 44.1, 48 or 96 kHz; code 11 reserved.
// RQ8 - Bit 5 takes channels from first or last four TDM slots.
// RQ9 - Bit 4 sets TDM slot width 24/32 bits or 16 bits.
// RQ10 - Bit 3 swaps channel pair one/two with pair three/four.
// RQ11 - Bits 2:0 select right-justified widths, I2S, left-justified or DSP.
// RQ12 - Framed modes accept both 16-bit and 24-bit words.
// RQ13 - Reserved bits ignore writes, read zero; reserved codes stored only.
`timescale 1ns/1ps
`default_nettype none
module pwm_and_serial_port_config_regs (
    input wire logic clk, // System clock, 40 MHz
    input wire logic rst_n, // Sync reset, active low
    input wire logic wr_en, // Write strobe, one cycle
    input wire logic rd_en, // Read strobe, one cycle
    input wire logic [7:0] addr, // Register address
    input wire logic [7:0] wr_data, // Write data
    output logic [7:0] rd_data, // Read data, valid cycle after rd_en
    output logic rd_valid, // Read data valid pulse
    output logic [7:0] switch_mult, // Switching rate / fs, 0 = reserved
    output logic modulator_oversampling_select, // High for 128x
    output logic [6:0] phase_deg, // Phase offset, degrees
    output logic [1:0] input_rate_select, // Sample rate code
    output logic eight_slot_half_select, // Last four TDM slots
    output logic slot_16bit, // 16-bit TDM slot
    output logic pair_swap, // Channel pair swap
    output logic [2:0] input_format, // Serial input format code
    output logic [5:0] word_bits, // Right-justified width, 0 for framed
    output logic format_valid, // Format code usable
    output logic rate_combo_bad // 48x fs requested at 48 kHz
);
    logic [7:0] swmod_reg;
    logic [7:0] port_reg;
    logic sel_swmod;
    logic sel_port;

    assign sel_swmod = (addr == cfg_regs_pkg::SWMOD_OFFSET);
    assign sel_port = (addr == cfg_regs_pkg::PORT_OFFSET);

    // Switching register; reserved bits masked so they always hold zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            swmod_reg <= cfg_regs_pkg::SWMOD_RESET; // [RQ1]
        else if (wr_en && sel_swmod)
            swmod_reg <= wr_data & cfg_regs_pkg::SWMOD_WMASK; // [RQ1] [RQ13]
    end

    // Serial port register; every bit writable, reserved codes just stored
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            port_reg <= cfg_regs_pkg::PORT_RESET; // [RQ6]
        else if (wr_en && sel_port)
            port_reg <= wr_data; // [RQ6] [RQ13]
    end

    // Read port; unmapped addresses return zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_en;
            if (rd_en && sel_swmod)
                rd_data <= swmod_reg; // [RQ1]
            else if (rd_en && sel_port)
                rd_data <= port_reg; // [RQ6]
            else if (rd_en)
                rd_data <= 8'h00;
        end
    end

    switch_decode u_switch (
        .clk(clk),
        .rst_n(rst_n),
        .reg_value(swmod_reg),
        .switch_mult(switch_mult),
        .osr_128(modulator_oversampling_select),
        .phase_deg(phase_deg)
    );

    port_decode u_port (
        .clk(clk),
        .rst_n(rst_n),
        .reg_value(port_reg),
        .input_rate_select(input_rate_select),
        .eight_slot_half_select(eight_slot_half_select),
        .slot_16bit(slot_16bit),
        .pair_swap(pair_swap),
        .input_format(input_format),
        .word_bits(word_bits),
        .format_valid(format_valid)
    );

    // Flags the unsupported combination; the device does not refuse it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rate_combo_bad <= 1'b0;
        else
            rate_combo_bad <= (swmod_reg[cfg_regs_pkg::SWRATE_LSB +: 3] == 3'h7)
                && (port_reg[cfg_regs_pkg::RATE_LSB +: 2] == 2'h1); // [RQ3]
    end

    // Checks
    chk_swmod_reset: assert property (@(posedge clk) !rst_n |=> swmod_reg == 8'h62) // [RQ1]
        else $error("switching register reset value wrong");
    chk_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
        swmod_reg[7] == 1'b0 && swmod_reg[3] == 1'b0) // [RQ13]
        else $error("reserved bits not zero");
    chk_port_reset: assert property (@(posedge clk) !rst_n |=> port_reg == 8'h04) // [RQ6]
        else $error("serial port register reset value wrong");
    chk_port_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && addr == 8'h03 |=> port_reg == $past(wr_data)) // [RQ6]
        else $error("serial port write lost");
    chk_swmod_read: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == 8'h02 |=> rd_valid && rd_data == $past(swmod_reg)) // [RQ1]
        else $error("switching register read wrong");
    chk_mult_44: assert property (@(posedge clk) disable iff (!rst_n)
        swmod_reg[6:4] == 3'h6 && !wr_en |=> ##1 switch_mult == 8'h2C) // [RQ2]
        else $error("44x decode wrong");
    chk_rsvd_rate: assert property (@(posedge clk) disable iff (!rst_n)
        swmod_reg[6:4] == 3'h3 |=> switch_mult == 8'h00) // [RQ13]
        else $error("reserved rate not zero");
    chk_osr_follow: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> modulator_oversampling_select == $past(swmod_reg[2])) // [RQ4]
        else $error("oversampling select wrong");
    chk_phase_60: assert property (@(posedge clk) disable iff (!rst_n)
        swmod_reg[1:0] == 2'h3 |=> phase_deg == 7'd60) // [RQ5]
        else $error("phase 60 decode wrong");
    chk_rate_field: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> input_rate_select == $past(port_reg[7:6])) // [RQ7]
        else $error("rate select wrong");
    chk_slot_bits: assert property (@(posedge clk) disable iff (!rst_n) // [RQ8] [RQ9] [RQ10]
        1'b1 |=> {eight_slot_half_select, slot_16bit, pair_swap} == $past(port_reg[5:3]))
        else $error("slot controls wrong");
    chk_fmt_width: assert property (@(posedge clk) disable iff (!rst_n)
        port_reg[2:0] == 3'h1 |=> word_bits == 6'd20 && input_format == 3'h1) // [RQ11]
        else $error("format decode wrong");
    chk_framed_any: assert property (@(posedge clk) disable iff (!rst_n)
        port_reg[2:0] == 3'h6 |=> word_bits == 6'd0) // [RQ12]
        else $error("framed mode width forced");

    cov_swmod_write: cover property (@(posedge clk) disable iff (!rst_n)
        wr_en && sel_swmod);
    cov_port_read: cover property (@(posedge clk) disable iff (!rst_n)
        rd_en && sel_port);
    cov_bad_combo: cover property (@(posedge clk) disable iff (!rst_n) rate_combo_bad);
    cov_swap: cover property (@(posedge clk) disable iff (!rst_n) pair_swap);
endmodule : pwm_and_serial_port_config_regs
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
 * Self-checking bench for the switching and serial port config registers.
 * Assumes the one-cycle strobe register port with the design's fixed latencies.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [7:0] n;
        logic [6:0] p;} row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_data, switch_mult, sw_cur, port_cur, exp_mult;
    logic [6:0] phase_deg, exp_ph;
    logic [5:0] word_bits, exp_wb;
    logic [2:0] input_format;
    logic [1:0] input_rate_select;
    logic osr, half, slot16, swap, fv, bad, rd_valid;
    int n_mismatch = 0;
    int num_checks = 0;
    // Address, written, read back, multiple or word width, phase
    row_t rows [16] = '{'{8'h02, 8'h8F, 8'h07, 8'h08, 7'h3C}, '{8'h02, 8'h11, 8'h11, 8'h0A, 7'h1E},
        '{8'h02, 8'h20, 8'h20, 8'h00, 7'h00}, '{8'h02, 8'h38, 8'h30, 8'h00, 7'h00},
        '{8'h02, 8'h42, 8'h42, 8'h00, 7'h2D}, '{8'h02, 8'h54, 8'h54, 8'h26, 7'h00},
        '{8'h02, 8'hE9, 8'h61, 8'h2C, 7'h1E}, '{8'h02, 8'h77, 8'h77, 8'h30, 7'h3C},
        '{8'h03, 8'h00, 8'h00, 8'h18, 7'h00}, '{8'h03, 8'h69, 8'h69, 8'h14, 7'h00},
        '{8'h03, 8'h92, 8'h92, 8'h12, 7'h00}, '{8'h03, 8'hEB, 8'hEB, 8'h10, 7'h00},
        '{8'h03, 8'h1C, 8'h1C, 8'h00, 7'h00}, '{8'h03, 8'h05, 8'h05, 8'h00, 7'h00},
        '{8'h03, 8'h46, 8'h46, 8'h00, 7'h00}, '{8'h03, 8'hFF, 8'hFF, 8'h00, 7'h00}};

    pwm_and_serial_port_config_regs pwm_and_serial_port_config_regs_i (.clk(clk), .rst_n(rst_n),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .switch_mult(switch_mult), .modulator_oversampling_select(osr),
        .phase_deg(phase_deg), .input_rate_select(input_rate_select),
        .eight_slot_half_select(half), .slot_16bit(slot16), .pair_swap(swap),
        .input_format(input_format), .word_bits(word_bits), .format_valid(fv),
        .rate_combo_bad(bad));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task check(input logic [7:0] seen, input logic [7:0] expv);
        num_checks++;
        if (seen !== expv)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    task end_of_test;
        if (n_mismatch == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // Strobes rise after one edge and are sampled at the next
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] expv);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check({7'h00, rd_valid}, 8'h01);
        check(rd_data, expv);
    endtask : rd

    // Decoded outputs land one edge after the write edge; checked after the second
    task dec;
        repeat (2) @(posedge clk);
        #1;
        check(switch_mult, exp_mult);
        check({7'h00, osr}, {7'h00, sw_cur[2]});
        check({1'b0, phase_deg}, {1'b0, exp_ph});
        check({input_rate_select, half, slot16, swap, input_format}, port_cur);
        check({2'h0, word_bits}, {2'h0, exp_wb});
        check({7'h00, fv}, {7'h00, port_cur[2:0] != 3'h7});
        check({7'h00, bad}, {7'h00, sw_cur[6:4] == 3'h7 && port_cur[7:6] == 2'h1});
    endtask : dec

    // Reset restores both registers and every decoded output
    task do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        sw_cur = 8'h62;
        port_cur = 8'h04;
        exp_mult = 8'h2C;
        exp_ph = 7'h2D;
        exp_wb = 6'h00;
        #1;
        check({7'h00, rd_valid}, 8'h00);
        check(rd_data, 8'h00);
        dec();
        rd(8'h02, 8'h62);
        rd(8'h03, 8'h04);
    endtask : do_reset

    // Watchdog: a hang ends the run as a failure
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("MISMATCH t=%0t run did not finish", $time);
        end_of_test();
    end

    // Table pass, then back-to-back, collision, unmapped and reset cases
    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            if (rows[i].a == 8'h02)
            begin
                sw_cur = rows[i].r;
                exp_mult = rows[i].n;
                exp_ph = rows[i].p;
            end
            else
            begin
                port_cur = rows[i].r;
                exp_wb = rows[i].n[5:0];
            end
            dec();
            rd(rows[i].a, rows[i].r);
        end
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= 8'h02;
        wr_data <= 8'h05;
        @(posedge clk);
        addr <= 8'h03;
        wr_data <= 8'h5D;
        @(posedge clk);
        wr_en <= 1'b0;
        sw_cur = 8'h05;
        port_cur = 8'h5D;
        exp_mult = 8'h08;
        exp_ph = 7'h1E;
        exp_wb = 6'h00;
        dec();
        @(posedge clk);
        wr_en <= 1'b1;
        rd_en <= 1'b1;
        addr <= 8'h03;
        wr_data <= 8'hA5;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        #1;
        check(rd_data, 8'h5D);
        port_cur = 8'hA5;
        rd(8'h03, 8'hA5);
        dec();
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'h00);
        rd(8'h00, 8'h00);
        rd(8'h02, 8'h05);
        repeat (3) @(posedge clk);
        #1;
        check({7'h00, rd_valid}, 8'h00);
        check(rd_data, 8'h05);
        do_reset();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
